//--- pkg/cset_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the compare unit
// Assumes: Word-aligned registers on a 32-bit AHB-Lite bus, 8-bit data in the low byte
// Notes:   Definitions only
`ifndef CSET_PARAMS_SVH
`define CSET_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL      6'h00
`define OFS_CMP_LOW      6'h04
`define OFS_CMP_HIGH     6'h08
`define OFS_COUNT_LOW    6'h0C
`define OFS_COUNT_HIGH   6'h10
`define OFS_STATUS       6'h14
`define OFS_MASK         6'h18
`define OFS_TB_CTRL      6'h1C
`define OFS_STATE        6'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_MATCH_FLAG   0
`define BIT_OVF_FLAG     1
`define BIT_TB_RUN       0
`define BIT_PIN_DIR      1
`define BIT_ST_LATCH     0
`define BIT_ST_DRIVE     1
`define BIT_ST_PENDING   2
`define FLAG_COUNT       2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_MODE         4'h0
`define RST_BYTE16       16'h0000
`define RST_FLAGS        2'h0
`define RST_TB_RUN       1'b0
`define RST_PIN_DIR      1'b1
`define RST_WORD         32'h0000_0000

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define SYNC_STAGES      2
`define COUNT_MAX        16'hFFFF

`endif

//--- pkg/cset_pkg.sv
// Purpose: Types shared by the compare unit and its bus port
// Assumes: Codes of the mode field as seen by software
// Notes:   Numbers other than encodings live in cset_params.svh
package cset_pkg;

  // ----------------------------------------------------------------
  // Compare mode field codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF     = 4'h0,
    MODE_TOGGLE  = 4'h2,
    MODE_SET     = 4'h8,
    MODE_CLEAR   = 4'h9,
    MODE_SWINT   = 4'hA,
    MODE_SPECIAL = 4'hB
  } compare_mode_type;

  // ----------------------------------------------------------------
  // Bus port states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0001,
    ST_WRITE     = 4'b0010,
    ST_READ_WAIT = 4'b0100,
    ST_READ_DONE = 4'b1000
  } slave_state_type;

endpackage

//--- pkg/reg_access_if.sv
// Purpose: Register access path between the bus port and the compare core
// Assumes: One write strobe per cycle, read data combinational from the core
// Notes:   Offset is the whole byte offset, address bits 5:0 with the two low bits kept
`timescale 1ns/1ns
interface reg_access_if;
  logic        wr_stb;
  logic [5:0]  wr_ofs;
  logic [31:0] wr_data;
  logic [5:0]  rd_ofs;
  logic        rd_hit;
  logic [31:0] rd_data;

  modport port (output wr_stb, output wr_ofs, output wr_data, output rd_ofs, output rd_hit, input rd_data);
  modport core (input wr_stb, input wr_ofs, input wr_data, input rd_ofs, input rd_hit, output rd_data);
endinterface

//--- src/ahb_reg_port.sv
// Purpose: AHB-Lite slave front end for the compare unit registers
// Assumes: Single whole-word transfers, response always OKAY
// Notes:   Writes take no wait state, reads take one wait state
`timescale 1ns/1ns
`include "cset_params.svh"
module ahb_reg_port
  import cset_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  reg_access_if.port       regs
);

  slave_state_type state_reg;
  slave_state_type state_next;
  logic [31:0]     addr_reg;
  logic [31:0]     rdata_reg;
  wire             start_xfer;
  wire             addr_hit;

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  assign start_xfer = hsel & hready & htrans[1];
  assign addr_hit   = (addr_reg[31:6] == 26'h000_0000) && (addr_reg[1:0] == 2'b00);

  // Next state: a new address phase may follow any completed data phase
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_WRITE, ST_READ_DONE: begin
        if (start_xfer) begin
          state_next = hwrite ? ST_WRITE : ST_READ_WAIT;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_READ_WAIT: state_next = ST_READ_DONE;
      default:      state_next = ST_IDLE;
    endcase
  end

  // State, captured address and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      addr_reg  <= `RST_WORD;
      rdata_reg <= `RST_WORD;
    end else begin
      state_reg <= state_next;
      if (start_xfer && state_reg != ST_READ_WAIT) begin
        addr_reg <= haddr;
      end
      if (state_reg == ST_READ_WAIT) begin
        rdata_reg <= regs.rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core side and bus answers
  // ----------------------------------------------------------------
  assign regs.wr_stb  = (state_reg == ST_WRITE) & addr_hit;
  assign regs.wr_ofs  = addr_reg[5:0];
  assign regs.wr_data = hwdata;
  assign regs.rd_ofs  = addr_reg[5:0];
  assign regs.rd_hit  = addr_hit;
  assign hrdata       = rdata_reg;
  assign hreadyout    = (state_reg != ST_READ_WAIT);
  assign hresp        = 1'b0;

endmodule

//--- src/compare_special_event_trigger.sv
// Purpose: Output compare unit with special event trigger and its 16-bit time base
// Assumes: Time base tick and converter enable arrive as asynchronous pins
// Notes:   Registers are reached over AHB-Lite through ahb_reg_port
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`include "cset_params.svh"

// What this block does
// R1: Compare value and time base count are checked for equality every cycle in the compare modes.
// R2: A match toggles, sets or clears the output, triggers, or only interrupts.
// R3: Every compare mode raises the compare match flag on a match.
// R4: Software interrupt mode leaves the pin undriven and only sets the flag.
// R5: Special event mode resets the time base and starts conversion if enabled.
// R6: A trigger clear never sets the time base overflow flag.
// R7: Trigger is issued at once; the count clears at the next tick.
// R8: If the match vanishes before that tick, the count is not cleared.
// R9: A software write to a count byte beats a trigger clear.
// R10: Writing zero to the control register forces the output latch low.
// R11: Software runs the time base synchronously during compare.
// R12: Software keeps the time base synchronous when using the trigger.
// R13: Software makes the pin an output before the latch can drive it.
// R14: A match sets the compare flag, held until software clears it.
// R15: Toggle mode inverts the latch once per match, not per cycle.
module compare_special_event_trigger
  import cset_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        timebase_tick_pin,
  input  wire logic        converter_enable_pin,
  output logic             compare_out,
  output logic             compare_out_oe_n,
  output logic             special_event_trigger,
  output logic             convert_start,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Modes that run the comparator
  function automatic logic is_compare_mode(input logic [3:0] m);
    return (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR) ||
           (m == MODE_SWINT) || (m == MODE_SPECIAL);
  endfunction

  // Modes that take control of the pin
  function automatic logic is_pin_mode(input logic [3:0] m);
    return (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR);
  endfunction

  // ----------------------------------------------------------------
  // Bus port
  // ----------------------------------------------------------------
  reg_access_if regs ();

  ahb_reg_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .regs      (regs)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0]              mode_reg;
  logic [15:0]             cmp_reg;
  logic [15:0]             count_reg;
  logic [15:0]             count_next;
  logic [`FLAG_COUNT-1:0]  status_reg;
  logic [`FLAG_COUNT-1:0]  status_next;
  logic [`FLAG_COUNT-1:0]  mask_reg;
  logic                    run_reg;
  logic                    pin_dir_reg;
  logic                    latch_reg;
  logic                    latch_next;
  logic                    match_q_reg;
  logic                    pend_reg;
  logic                    pend_next;
  logic                    trig_reg;
  logic                    conv_reg;
  logic                    ovf_set;
  logic [`SYNC_STAGES-1:0] tick_sync_reg;
  logic                    tick_q_reg;
  logic [`SYNC_STAGES-1:0] conv_en_sync_reg;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire       wr_control = regs.wr_stb && regs.wr_ofs == `OFS_CONTROL;
  wire       wr_cmp_lo  = regs.wr_stb && regs.wr_ofs == `OFS_CMP_LOW;
  wire       wr_cmp_hi  = regs.wr_stb && regs.wr_ofs == `OFS_CMP_HIGH;
  wire       wr_cnt_lo  = regs.wr_stb && regs.wr_ofs == `OFS_COUNT_LOW;
  wire       wr_cnt_hi  = regs.wr_stb && regs.wr_ofs == `OFS_COUNT_HIGH;
  wire       wr_status  = regs.wr_stb && regs.wr_ofs == `OFS_STATUS;
  wire       wr_mask    = regs.wr_stb && regs.wr_ofs == `OFS_MASK;
  wire       wr_tb_ctrl = regs.wr_stb && regs.wr_ofs == `OFS_TB_CTRL;
  wire       wr_count   = wr_cnt_lo | wr_cnt_hi;
  wire [7:0] wbyte      = regs.wr_data[7:0];

  // ----------------------------------------------------------------
  // Synchronisers for the asynchronous pins
  // ----------------------------------------------------------------

  // Two flops each; only the last stage feeds logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_sync_reg    <= '0;
      tick_q_reg       <= 1'b0;
      conv_en_sync_reg <= '0;
    end else begin
      tick_sync_reg    <= {tick_sync_reg[0], timebase_tick_pin};
      tick_q_reg       <= tick_sync_reg[1];
      conv_en_sync_reg <= {conv_en_sync_reg[0], converter_enable_pin};
    end
  end

  // Rising edge of the time base clock, gated by the run bit
  wire tick       = tick_sync_reg[1] & ~tick_q_reg & run_reg;
  wire conv_en    = conv_en_sync_reg[1];

  // ----------------------------------------------------------------
  // Comparator and match event
  // ----------------------------------------------------------------
  wire cmp_active  = is_compare_mode(mode_reg);
  wire equal_now   = cmp_active & (count_reg == cmp_reg);          // [R1]
  wire match_event = equal_now & ~match_q_reg;                     // [R15]
  wire special     = (mode_reg == MODE_SPECIAL);
  wire pin_mode    = is_pin_mode(mode_reg);

  // ----------------------------------------------------------------
  // Output latch
  // ----------------------------------------------------------------

  // Pin action of the selected mode, once per match
  always_comb begin
    latch_next = latch_reg;
    if (match_event) begin
      case (mode_reg)
        MODE_TOGGLE: latch_next = ~latch_reg;                      // [R2] [R15]
        MODE_SET:    latch_next = 1'b1;                            // [R2]
        MODE_CLEAR:  latch_next = 1'b0;                            // [R2]
        default:     latch_next = latch_reg;                       // [R4] [R5]
      endcase
    end
    if (wr_control && wbyte == 8'h00) begin
      latch_next = 1'b0;                                           // [R10]
    end
  end

  // ----------------------------------------------------------------
  // Special event pending and time base
  // ----------------------------------------------------------------

  // Pending clear waits for the next tick and dies with the match
  always_comb begin
    pend_next = pend_reg;
    if (match_event && special) begin
      pend_next = 1'b1;                                            // [R5] [R7]
    end
    if (!equal_now || !special || tick || wr_count) begin
      pend_next = match_event & special & ~tick & ~wr_count;       // [R8] [R9]
    end
  end

  // Count: software write first, then trigger clear, then increment
  always_comb begin
    count_next = count_reg;
    ovf_set    = 1'b0;
    if (wr_count) begin
      if (wr_cnt_lo) begin
        count_next = {count_reg[15:8], wbyte};                     // [R9]
      end else begin
        count_next = {wbyte, count_reg[7:0]};                      // [R9]
      end
    end else if (tick) begin
      if (pend_reg && equal_now && special) begin
        count_next = 16'h0000;                                     // [R5] [R7] [R8]
      end else begin
        count_next = count_reg + 16'h0001;
        ovf_set    = (count_reg == `COUNT_MAX);                    // [R6]
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags, set wins over the write-one clear
  // ----------------------------------------------------------------
  wire [`FLAG_COUNT-1:0] flag_set;
  assign flag_set[`BIT_MATCH_FLAG] = match_event;                  // [R3] [R4] [R14]
  assign flag_set[`BIT_OVF_FLAG]   = ovf_set;                      // [R6]

  genvar gi;
  generate
    for (gi = 0; gi < `FLAG_COUNT; gi = gi + 1) begin : g_flag
      assign status_next[gi] = flag_set[gi] |
                               (status_reg[gi] & ~(wr_status & regs.wr_data[gi])); // [R14]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------

  // Software-owned settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg    <= `RST_MODE;
      cmp_reg     <= `RST_BYTE16;
      mask_reg    <= `RST_FLAGS;
      run_reg     <= `RST_TB_RUN;
      pin_dir_reg <= `RST_PIN_DIR;
    end else begin
      if (wr_control) mode_reg <= wbyte[3:0];
      if (wr_cmp_lo)  cmp_reg[7:0] <= wbyte;
      if (wr_cmp_hi)  cmp_reg[15:8] <= wbyte;
      if (wr_mask)    mask_reg <= wbyte[`FLAG_COUNT-1:0];
      if (wr_tb_ctrl) begin
        run_reg     <= wbyte[`BIT_TB_RUN];
        pin_dir_reg <= wbyte[`BIT_PIN_DIR];
      end
    end
  end

  // Hardware-owned state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg   <= `RST_BYTE16;
      status_reg  <= `RST_FLAGS;
      latch_reg   <= 1'b0;
      match_q_reg <= 1'b0;
      pend_reg    <= 1'b0;
    end else begin
      count_reg   <= count_next;
      status_reg  <= status_next;
      latch_reg   <= latch_next;
      match_q_reg <= equal_now;
      pend_reg    <= pend_next;
    end
  end

  // Trigger and conversion start pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_reg <= 1'b0;
      conv_reg <= 1'b0;
    end else begin
      trig_reg <= match_event & special;                           // [R7]
      conv_reg <= match_event & special & conv_en;                 // [R5]
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [7:0] state_byte = {5'h00, pend_reg, pin_mode & ~pin_dir_reg, latch_reg};

  always_comb begin
    regs.rd_data = `RST_WORD;
    if (regs.rd_hit) begin
      case (regs.rd_ofs)
        `OFS_CONTROL:    regs.rd_data = {28'h000_0000, mode_reg};
        `OFS_CMP_LOW:    regs.rd_data = {24'h00_0000, cmp_reg[7:0]};
        `OFS_CMP_HIGH:   regs.rd_data = {24'h00_0000, cmp_reg[15:8]};
        `OFS_COUNT_LOW:  regs.rd_data = {24'h00_0000, count_reg[7:0]};
        `OFS_COUNT_HIGH: regs.rd_data = {24'h00_0000, count_reg[15:8]};
        `OFS_STATUS:     regs.rd_data = {30'h0000_0000, status_reg};
        `OFS_MASK:       regs.rd_data = {30'h0000_0000, mask_reg};
        `OFS_TB_CTRL:    regs.rd_data = {30'h0000_0000, pin_dir_reg, run_reg};
        `OFS_STATE:      regs.rd_data = {24'h00_0000, state_byte};
        default:         regs.rd_data = `RST_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Pin driven only in pin modes with the direction bit cleared
  assign compare_out           = latch_reg;
  assign compare_out_oe_n      = ~(pin_mode & ~pin_dir_reg);       // [R4] [R5] [R13]
  assign special_event_trigger = trig_reg;
  assign convert_start         = conv_reg;
  assign irq                   = |(status_reg & mask_reg);

endmodule

//--- tb/compare_unit_assertions.sv
// Purpose: Port-level checks of the compare unit and its register bus
// Assumes: hready is tied to hreadyout, one clock domain
// Notes:   Bound to the design top at the foot of this file
`timescale 1ns/1ns
module compare_unit_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        converter_enable_pin,
  input wire logic        compare_out,
  input wire logic        compare_out_oe_n,
  input wire logic        special_event_trigger,
  input wire logic        convert_start,
  input wire logic        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Helper: data phase of a control write
  // ----------------------------------------------------------------
  logic ctrl_wr_dp;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_wr_dp <= 1'b0;
    else if (hready) ctrl_wr_dp <= hsel && htrans[1] && hwrite && (haddr == 32'h0000_0000);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  resp_okay_a: assert property (hresp == 1'b0) else $error("bus response not OKAY");
  write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write took a wait state");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  trig_pulse_a: assert property (special_event_trigger |=> !special_event_trigger)
    else $error("trigger longer than one cycle");
  conv_with_trig_a: assert property (convert_start |-> special_event_trigger)
    else $error("conversion start without trigger");
  conv_needs_enable_a: assert property (!converter_enable_pin && $past(!converter_enable_pin) &&
    $past(!converter_enable_pin, 2) && $past(!converter_enable_pin, 3) |-> !convert_start)
    else $error("conversion start while converter disabled");
  trig_pin_free_a: assert property (special_event_trigger |-> compare_out_oe_n)
    else $error("pin driven in trigger mode");
  ctrl_zero_low_a: assert property (ctrl_wr_dp && hready && hwdata[7:0] == 8'h00 |=> !compare_out)
    else $error("latch not forced low by zero control write");
  latch_once_a: assert property (!$stable(compare_out) |=> $stable(compare_out))
    else $error("latch changed on two cycles in a row");

  // Main scenarios reached
  cover property (special_event_trigger);
  cover property (convert_start);
  cover property ($rose(irq));
  cover property ($fell(compare_out_oe_n));
endmodule

bind compare_special_event_trigger compare_unit_checker compare_unit_checker_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .converter_enable_pin, .compare_out, .compare_out_oe_n, .special_event_trigger, .convert_start, .irq
);

//--- tb/timebase_far_end.sv
// Purpose: Time base clock source and converter enable beside the compare unit
// Assumes: Tick pulses are slow against hclk and launched from it
// Notes:   Tick line stays low between requested pulses
`timescale 1ns/1ns
module timebase_far_end (
  input wire logic hclk,
  output logic     timebase_tick_pin,
  output logic     converter_enable_pin
);
  initial begin
    timebase_tick_pin = 1'b0;
    converter_enable_pin = 1'b0;
  end

  // Tick edges derived from the system clock keep the count synchronous
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      timebase_tick_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      timebase_tick_pin <= 1'b0;
      repeat (8) @(posedge hclk);
    end
  endtask

  // Converter enable level, synced by the unit
  task automatic set_enable(input logic v);
    @(posedge hclk);
    converter_enable_pin <= v;
  endtask
endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the compare unit over its register bus
// Assumes: Write answers in one cycle, read after one wait state
// Notes:   Compare value 5 is used for every match
`timescale 1ns/1ns
module tb_top;
  import cset_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [25:0] page = 26'h000_0000;
  logic        tick_pin;
  logic        conv_en;
  logic        compare_out;
  logic        oe_n;
  logic        trig;
  logic        conv;
  logic        irq;
  int          mismatches = 0;
  int          n_checks = 0;
  int          trig_n;
  int          conv_n;
  logic [31:0] rd;
  compare_mode_type modes[6] = '{MODE_TOGGLE, MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_SWINT, MODE_SPECIAL};
  logic        exp_oe[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic        exp_out[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

  compare_special_event_trigger compare_special_event_trigger_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .timebase_tick_pin(tick_pin), .converter_enable_pin(conv_en), .compare_out(compare_out),
    .compare_out_oe_n(oe_n), .special_event_trigger(trig), .convert_start(conv), .irq(irq));
  timebase_far_end timebase_far_end_inst (.hclk(hclk), .timebase_tick_pin(tick_pin), .converter_enable_pin(conv_en));

  // ----------------------------------------------------------------
  // Clock, pulse counters and watchdog
  // ----------------------------------------------------------------
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (trig === 1'b1) trig_n++;
    if (conv === 1'b1) conv_n++;
  end
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Bus access and comparison tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {page, a};
    hsize <= 3'b010;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hsize <= 3'b000;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    q = hrdata;
    if (n >= 50) mismatches++;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000, rd);
    check(what, exp, rd);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b000;
    hwdata = 32'h0000_0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(6'h1C, 32'h0000_0002, "time base control reset");
    rd_chk(6'h14, 32'h0000_0000, "status reset");
    wr(6'h3C, 32'hFFFF_FFFF);
    rd_chk(6'h3C, 32'h0000_0000, "unmapped read");
    check("bus response", 32'h0, {31'h0, hresp});
    wr(6'h1C, 32'h0000_0001);
    wr(6'h04, 32'h0000_0005);
    wr(6'h08, 32'h0000_0000);
    page = 26'h000_0001;
    wr(6'h04, 32'h0000_00FF);
    page = 26'h000_0000;
    rd_chk(6'h04, 32'h0000_0005, "high page write ignored");
    for (int i = 0; i < 6; i++) begin
      if (modes[i] == MODE_SPECIAL) timebase_far_end_inst.set_enable(1'b1);
      wr(6'h0C, 32'h0000_0004);
      wr(6'h00, {28'h0, modes[i]});
      wr(6'h14, 32'h0000_0003);
      trig_n = 0;
      conv_n = 0;
      timebase_far_end_inst.pulses(1);
      check("compare output", {31'h0, exp_out[i]}, {31'h0, compare_out});
      check("pin enable", {31'h0, exp_oe[i]}, {31'h0, oe_n});
      rd_chk(6'h14, 32'h0000_0001, "match flag");
      check("trigger pulses", (modes[i] == MODE_SPECIAL), trig_n);
      check("conversion pulses", (modes[i] == MODE_SPECIAL), conv_n);
    end
    rd_chk(6'h0C, 32'h0000_0005, "count held until tick");
    timebase_far_end_inst.pulses(1);
    rd_chk(6'h0C, 32'h0000_0000, "count cleared by trigger");
    rd_chk(6'h14, 32'h0000_0001, "no overflow on trigger clear");
    wr(6'h0C, 32'h0000_0004);
    timebase_far_end_inst.pulses(1);
    wr(6'h04, 32'h0000_0009);
    timebase_far_end_inst.pulses(1);
    rd_chk(6'h0C, 32'h0000_0006, "clear dropped when match removed");
    wr(6'h04, 32'h0000_0005);
    wr(6'h0C, 32'h0000_0004);
    timebase_far_end_inst.pulses(1);
    wr(6'h0C, 32'h0000_0005);
    timebase_far_end_inst.pulses(1);
    rd_chk(6'h0C, 32'h0000_0006, "count write beats trigger");
    @(posedge hclk);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(6'h18, 32'h0000_0001);
    @(posedge hclk);
    check("irq unmasked", 32'h1, {31'h0, irq});
    wr(6'h14, 32'h0000_0001);
    @(posedge hclk);
    check("irq after clear", 32'h0, {31'h0, irq});
    wr(6'h00, 32'hFFFF_FF00);
    @(posedge hclk);
    check("latch after zero control", 32'h0, {31'h0, compare_out});
    wr(6'h10, 32'h0000_00FF);
    wr(6'h0C, 32'h0000_00FF);
    timebase_far_end_inst.pulses(1);
    rd_chk(6'h14, 32'h0000_0002, "overflow by increment");
    rd_chk(6'h0C, 32'h0000_0000, "count after wrap");
    print_verdict();
  end
endmodule
